// ==== common/codec_cfg_pkg.sv ====
package codec_cfg_pkg;

  // ------------------------------------------------------------
  // register addresses (3-bit field of the control word)
  // ------------------------------------------------------------
  localparam logic [2:0] ADDR_MODE  = 3'h0;
  localparam logic [2:0] ADDR_CLOCK = 3'h1;
  localparam logic [2:0] ADDR_POWER = 3'h2;
  localparam logic [2:0] ADDR_GAIN  = 3'h3;
  localparam logic [2:0] ADDR_DAC   = 3'h4;

  localparam logic [7:0] REG_RESET = 8'h00;

  // ------------------------------------------------------------
  // field positions
  // ------------------------------------------------------------
  localparam int MODE_OPMODE_BIT  = 0;
  localparam int MODE_MIXED_BIT   = 1;
  localparam int MODE_CASCADE_LSB = 4;
  localparam int MODE_SWRESET_BIT = 7;
  localparam int CLK_RATE_LSB     = 0;
  localparam int CLK_SCLK_LSB     = 2;
  localparam int CLK_MDIV_LSB     = 4;
  localparam int CLK_ECHO_BIT     = 7;
  localparam int PWR_TAP_BIT      = 1;
  localparam int PWR_AMP_BIT      = 2;
  localparam int PWR_ADC_BIT      = 3;
  localparam int GAIN_IN_LSB      = 0;
  localparam int GAIN_MODRST_BIT  = 3;
  localparam int GAIN_OUT_LSB     = 4;
  localparam int DAC_ADV_LSB      = 0;

  // ------------------------------------------------------------
  // divider and timing constants
  // ------------------------------------------------------------
  localparam logic [11:0] SRATE_DIV_MAX  = 12'h0800;
  localparam logic [3:0]  SCLK_DIV_MAX   = 4'h8;
  localparam logic [2:0]  MDIV_MAX_CODE  = 3'h4;
  localparam int          SWRESET_CYCLES = 4;

  // control word from the serial port
  typedef struct packed {
    logic [2:0] addr;
    logic [7:0] data;
  } wr_req_t;

  // decoded configuration
  typedef struct packed {
    logic       opModeData;
    logic       mixedModeEnable;
    logic [2:0] cascadeCount;
    logic [1:0] sampleRateSel;
    logic [1:0] serialClkSel;
    logic [2:0] masterClkSel;
    logic       controlEchoEnable;
    logic       analogTapPower;
    logic       inputAmpPower;
    logic       adcPower;
    logic [2:0] inputGain;
    logic       modulatorReset;
    logic [2:0] outputGain;
    logic [4:0] dacAdvance;
  } cfg_t;

endpackage : codec_cfg_pkg

// ==== rtl/codec_config_registers.sv ====
// Behaviour
// - mode bit 0: program 0, data 1
// - mode bits 6:4 hold cascade count
// - clock bits 1:0 select sample rate
// - clock bits 3:2 select serial divider
// - clock bits 6:4 select master divider
// - clock bit 7 enables control echo
// - power bit 1 powers analog tap
// - power bit 2 powers input amplifier
// - power bit 3 powers the ADC
// - gain bits 2:0 select input gain
// - gain bit 3 holds modulator reset
// - gain bits 6:4 select output gain
// - dac bits 4:0 set load advance
// - sample divisor 2048,1024,512,256; default 2048
// - serial divisor 8,4,2,1; default 8
// - master divisor 1..5; codes 5-7 undivided
// - advance step is 1/32 sample period
`timescale 1ns/100ps
module codec_config_registers (
  input  wire logic                  mclk,
  input  wire logic                  rst_n,
  input  wire logic                  wrValid,
  input  wire codec_cfg_pkg::wr_req_t wrReq,
  input  wire logic [2:0]            rdAddr,
  output logic [7:0]                 rdData,
  output codec_cfg_pkg::cfg_t        cfg,
  output logic [11:0]                sampleDivisor,
  output logic [3:0]                 serialDivisor,
  output logic [2:0]                 masterDivisor,
  output logic                       swResetBusy
);

  // ----------------------------------------------------------
  // register storage
  // ----------------------------------------------------------
  logic [7:0] modeReg_r;
  logic [7:0] clockReg_r;
  logic [7:0] powerReg_r;
  logic [7:0] gainReg_r;
  logic [7:0] dacReg_r;
  logic [2:0] swCnt_r;

  wire wrMode  = wrValid && wrReq.addr == codec_cfg_pkg::ADDR_MODE;
  wire wrClock = wrValid && wrReq.addr == codec_cfg_pkg::ADDR_CLOCK;
  wire wrPower = wrValid && wrReq.addr == codec_cfg_pkg::ADDR_POWER;
  wire wrGain  = wrValid && wrReq.addr == codec_cfg_pkg::ADDR_GAIN;
  wire wrDac   = wrValid && wrReq.addr == codec_cfg_pkg::ADDR_DAC;

  // software reset: setting the reset bit clears the bank for a few cycles;
  // writes are ignored while it runs so the clear cannot be half undone
  wire swKick  = wrMode && wrReq.data[codec_cfg_pkg::MODE_SWRESET_BIT] && !swResetBusy;
  wire swHold  = swCnt_r != 3'h0;
  wire wrOk    = !swHold;
  wire [2:0] swCntNxt = swKick ? 3'(codec_cfg_pkg::SWRESET_CYCLES)
                      : (swHold ? swCnt_r - 3'h1 : 3'h0);

  function automatic logic [7:0] upd(input logic hit, input logic [7:0] cur,
                                     input logic [7:0] val);
    upd = hit ? val : cur;
  endfunction : upd

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      modeReg_r  <= codec_cfg_pkg::REG_RESET;
      clockReg_r <= codec_cfg_pkg::REG_RESET;
      powerReg_r <= codec_cfg_pkg::REG_RESET;
      gainReg_r  <= codec_cfg_pkg::REG_RESET;
      dacReg_r   <= codec_cfg_pkg::REG_RESET;
      swCnt_r    <= 3'h0;
    end else if (swKick || swHold) begin
      modeReg_r  <= codec_cfg_pkg::REG_RESET;
      clockReg_r <= codec_cfg_pkg::REG_RESET;
      powerReg_r <= codec_cfg_pkg::REG_RESET;
      gainReg_r  <= codec_cfg_pkg::REG_RESET;
      dacReg_r   <= codec_cfg_pkg::REG_RESET;
      swCnt_r    <= swCntNxt;
    end else begin
      // reserved bits stored as written, power bit 7 included
      modeReg_r  <= upd(wrMode && wrOk, modeReg_r, wrReq.data);
      clockReg_r <= upd(wrClock && wrOk, clockReg_r, wrReq.data);
      powerReg_r <= upd(wrPower && wrOk, powerReg_r, wrReq.data);
      gainReg_r  <= upd(wrGain && wrOk, gainReg_r, wrReq.data);
      dacReg_r   <= upd(wrDac && wrOk, dacReg_r, wrReq.data);
      swCnt_r    <= swCntNxt;
    end
  end

  // ----------------------------------------------------------
  // field decode
  // ----------------------------------------------------------
  codec_cfg_pkg::cfg_t cfgNxt;
  always_comb begin
    cfgNxt                   = '0;
    cfgNxt.opModeData        = modeReg_r[codec_cfg_pkg::MODE_OPMODE_BIT];
    cfgNxt.mixedModeEnable   = modeReg_r[codec_cfg_pkg::MODE_MIXED_BIT];
    cfgNxt.cascadeCount      = modeReg_r[codec_cfg_pkg::MODE_CASCADE_LSB +: 3];
    cfgNxt.sampleRateSel     = clockReg_r[codec_cfg_pkg::CLK_RATE_LSB +: 2];
    cfgNxt.serialClkSel      = clockReg_r[codec_cfg_pkg::CLK_SCLK_LSB +: 2];
    cfgNxt.masterClkSel      = clockReg_r[codec_cfg_pkg::CLK_MDIV_LSB +: 3];
    cfgNxt.controlEchoEnable = clockReg_r[codec_cfg_pkg::CLK_ECHO_BIT];
    cfgNxt.analogTapPower    = powerReg_r[codec_cfg_pkg::PWR_TAP_BIT];
    cfgNxt.inputAmpPower     = powerReg_r[codec_cfg_pkg::PWR_AMP_BIT];
    cfgNxt.adcPower          = powerReg_r[codec_cfg_pkg::PWR_ADC_BIT];
    cfgNxt.inputGain         = gainReg_r[codec_cfg_pkg::GAIN_IN_LSB +: 3];
    cfgNxt.modulatorReset    = gainReg_r[codec_cfg_pkg::GAIN_MODRST_BIT];
    cfgNxt.outputGain        = gainReg_r[codec_cfg_pkg::GAIN_OUT_LSB +: 3];
    cfgNxt.dacAdvance        = dacReg_r[codec_cfg_pkg::DAC_ADV_LSB +: 5];
  end

  // divisor table lookups
  wire [11:0] sampleDivNxt = codec_cfg_pkg::SRATE_DIV_MAX >> cfgNxt.sampleRateSel;
  wire [3:0]  serialDivNxt = codec_cfg_pkg::SCLK_DIV_MAX >> cfgNxt.serialClkSel;
  wire [2:0]  masterDivNxt = (cfgNxt.masterClkSel > codec_cfg_pkg::MDIV_MAX_CODE)
                           ? 3'h1 : cfgNxt.masterClkSel + 3'h1;

  logic [7:0] rdDataNxt;
  always_comb begin
    case (rdAddr)
      codec_cfg_pkg::ADDR_MODE:  rdDataNxt = modeReg_r;
      codec_cfg_pkg::ADDR_CLOCK: rdDataNxt = clockReg_r;
      codec_cfg_pkg::ADDR_POWER: rdDataNxt = powerReg_r;
      codec_cfg_pkg::ADDR_GAIN:  rdDataNxt = gainReg_r;
      codec_cfg_pkg::ADDR_DAC:   rdDataNxt = dacReg_r;
      default:                   rdDataNxt = 8'h00;
    endcase
  end

  // ----------------------------------------------------------
  // registered outputs (one cycle behind the storage; swResetBusy changes on the same edge as swCnt_r)
  // ----------------------------------------------------------
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      rdData        <= 8'h00;
      cfg           <= '0;
      sampleDivisor <= codec_cfg_pkg::SRATE_DIV_MAX;
      serialDivisor <= codec_cfg_pkg::SCLK_DIV_MAX;
      masterDivisor <= 3'h1;
      swResetBusy   <= 1'b0;
    end else begin
      rdData        <= rdDataNxt;
      cfg           <= cfgNxt;
      sampleDivisor <= sampleDivNxt;
      serialDivisor <= serialDivNxt;
      masterDivisor <= masterDivNxt;
      swResetBusy   <= swKick || (swCntNxt != 3'h0);
    end
  end

  // ----------------------------------------------------------
  // checks
  // ----------------------------------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);

  // writes only count when no software clear is running
  wire quiet   = !swKick && !swHold;
  wire modeHit = quiet && wrMode && !wrReq.data[codec_cfg_pkg::MODE_SWRESET_BIT];

  // a field lands in cfg one edge after the write edge and is checked at the edge after that
  a_mode_readback: assert property (
    modeHit ##1 rdAddr == codec_cfg_pkg::ADDR_MODE |=> rdData == $past(wrReq.data, 2))
    else $error("mode readback wrong");
  a_opmode_bit: assert property (
    modeHit |-> ##2 cfg.opModeData == $past(wrReq.data[0], 2))
    else $error("opmode wrong");
  a_cascade_field: assert property (
    modeHit |-> ##2 cfg.cascadeCount == $past(wrReq.data[6:4], 2))
    else $error("cascade wrong");
  a_clock_fields: assert property (
    quiet && wrClock |-> ##2
    {cfg.controlEchoEnable, cfg.masterClkSel, cfg.serialClkSel, cfg.sampleRateSel}
      == $past(wrReq.data, 2))
    else $error("clock fields wrong");
  a_echo_bit: assert property (
    quiet && wrClock |-> ##2 cfg.controlEchoEnable == $past(wrReq.data[7], 2))
    else $error("echo bit wrong");
  a_power_bits: assert property (
    quiet && wrPower |-> ##2
    {cfg.adcPower, cfg.inputAmpPower, cfg.analogTapPower} == $past(wrReq.data[3:1], 2))
    else $error("power bits wrong");
  a_adc_power: assert property (
    quiet && wrPower |-> ##2 cfg.adcPower == $past(wrReq.data[3], 2))
    else $error("adc power wrong");
  a_gain_fields: assert property (
    quiet && wrGain |-> ##2
    {cfg.outputGain, cfg.modulatorReset, cfg.inputGain} == $past(wrReq.data[6:0], 2))
    else $error("gain fields wrong");
  a_modrst_bit: assert property (
    quiet && wrGain |-> ##2 cfg.modulatorReset == $past(wrReq.data[3], 2))
    else $error("modulator reset wrong");
  a_dac_field: assert property (
    quiet && wrDac |-> ##2 cfg.dacAdvance == $past(wrReq.data[4:0], 2))
    else $error("dac advance wrong");
  a_unmapped_write: assert property (
    quiet && wrValid && wrReq.addr > codec_cfg_pkg::ADDR_DAC |=> ##1 $stable(cfg))
    else $error("unmapped write changed a register");

  // divisors and cfg come from the same decode and edge, so they agree in
  // every cycle; a skew between them would hand the dividers a stale ratio
  a_sample_div: assert property (
    sampleDivisor == (cfg.sampleRateSel == 2'h0 ? 12'h0800
                    : cfg.sampleRateSel == 2'h1 ? 12'h0400
                    : cfg.sampleRateSel == 2'h2 ? 12'h0200 : 12'h0100))
    else $error("sample divisor wrong");
  a_serial_div: assert property (
    serialDivisor == (cfg.serialClkSel == 2'h0 ? 4'h8
                    : cfg.serialClkSel == 2'h1 ? 4'h4
                    : cfg.serialClkSel == 2'h2 ? 4'h2 : 4'h1))
    else $error("serial divisor wrong");
  a_master_div: assert property (
    cfg.masterClkSel >= 3'h5 |-> masterDivisor == 3'h1)
    else $error("master divisor wrong");
  a_master_ratio: assert property (
    cfg.masterClkSel <= 3'h4 |-> masterDivisor == cfg.masterClkSel + 3'h1)
    else $error("master ratio wrong");
  a_swreset_clears: assert property (
    swKick |-> ##2 cfg == '0 ##1 swResetBusy[*2] ##1 !swResetBusy)
    else $error("software reset wrong");
  a_clear_holds: assert property (
    swHold |=> cfg == '0 && rdData == 8'h00)
    else $error("write slipped into clear");

  c_mode_write: cover property (wrMode ##2 cfg.opModeData);
  c_sw_reset: cover property (swKick);
  c_fast_rate: cover property (sampleDivisor == 12'h0100);
  c_slow_master: cover property (masterDivisor == 3'h5);
  c_back_to_back: cover property (wrValid ##1 wrValid);

endmodule : codec_config_registers

// ==== test/dsp_port_model.sv ====
`timescale 1ns/100ps
module dsp_port_model (
  input  wire logic              mclk,
  output codec_cfg_pkg::wr_req_t wrReq,
  output logic                   wrValid
);
  initial begin
    wrValid = 1'b0;
    wrReq   = '0;
  end
  // one control word per call; back-to-back calls keep the strobe high
  task automatic send(input logic [2:0] a, input logic [7:0] d);
    @(negedge mclk);
    wrValid    = 1'b1;
    wrReq.addr = a;
    wrReq.data = (a == codec_cfg_pkg::ADDR_POWER) ? {1'b0, d[6:0]} : d;
    @(posedge mclk);
  endtask : send
  // stale word inverted so it cannot pass as a fresh one
  task automatic idle();
    @(negedge mclk);
    wrValid = 1'b0;
    wrReq   = ~wrReq;
  endtask : idle
endmodule : dsp_port_model

// ==== test/tb.sv ====
`timescale 1ns/100ps
module tb;
  logic                   mclk        = 1'b0;
  logic                   rst_n       = 1'b0;
  logic [2:0]             rdAddr      = 3'h0;
  logic                   wrValid;
  codec_cfg_pkg::wr_req_t wrReq;
  logic [7:0]             rdData;
  codec_cfg_pkg::cfg_t    cfg;
  logic [11:0]            sampleDivisor;
  logic [3:0]             serialDivisor;
  logic [2:0]             masterDivisor;
  logic                   swResetBusy;
  logic [7:0]             v;
  int                     n_fail      = 0;
  int                     comparisons = 0;
  always #2 mclk = ~mclk;
  dsp_port_model u_dsp (.mclk(mclk), .wrReq(wrReq), .wrValid(wrValid));
  codec_config_registers u_dut (.mclk(mclk), .rst_n(rst_n), .wrValid(wrValid),
    .wrReq(wrReq), .rdAddr(rdAddr), .rdData(rdData), .cfg(cfg),
    .sampleDivisor(sampleDivisor), .serialDivisor(serialDivisor),
    .masterDivisor(masterDivisor), .swResetBusy(swResetBusy));
  // ------------------------------------------------------------
  // access tasks
  // ------------------------------------------------------------
  task automatic chk(input string nm, input logic [11:0] got, input logic [11:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_fail++;
      $display("FAIL %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    u_dsp.send(a, d);
    u_dsp.idle();
    repeat (3) @(negedge mclk);
  endtask : wr
  task automatic rd(input logic [2:0] a, output logic [7:0] d);
    @(negedge mclk);
    rdAddr = a;
    repeat (2) @(negedge mclk);
    d = rdData;
  endtask : rd
  task automatic final_report();
    if (n_fail == 0 && comparisons > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : final_report
  initial begin
    #40000;
    n_fail++;
    final_report();
  end
  // ------------------------------------------------------------
  // tests
  // ------------------------------------------------------------
  initial begin
    logic [7:0] pw[2];
    logic [7:0] gn[2];
    logic [7:0] dc[2];
    logic [7:0] md[2];
    logic [2:0] m;
    pw = '{8'h0A, 8'h06};
    gn = '{8'h5B, 8'h24};
    dc = '{8'h1F, 8'h0A};
    md = '{8'h53, 8'h70};
    repeat (4) @(negedge mclk);
    rst_n = 1'b1;
    @(negedge mclk);
    chk("sampleDivisor", sampleDivisor, 12'h0800);
    chk("serialDivisor", {8'h00, serialDivisor}, 12'h0008);
    chk("masterDivisor", {9'h000, masterDivisor}, 12'h0001);
    for (int a = 0; a < 5; a++) begin
      wr(a[2:0], 8'h5A ^ a[7:0]);
      rd(a[2:0], v);
      chk("readback", {4'h0, v}, {4'h0, 8'h5A ^ a[7:0]});
    end
    for (int i = 0; i < 8; i++) begin
      m = i[2:0];
      wr(codec_cfg_pkg::ADDR_CLOCK, {i[0], m, ~i[1:0], i[1:0]});
      chk("sampleRateSel", {10'h000, cfg.sampleRateSel}, {10'h000, i[1:0]});
      chk("serialClkSel", {10'h000, cfg.serialClkSel}, {10'h000, ~i[1:0]});
      chk("masterClkSel", {9'h000, cfg.masterClkSel}, {9'h000, m});
      chk("echo", {11'h000, cfg.controlEchoEnable}, {11'h000, i[0]});
      chk("sampleDivisor", sampleDivisor, 12'h0800 >> i[1:0]);
      chk("serialDivisor", {8'h00, serialDivisor}, 12'h0008 >> (2'h3 - i[1:0]));
      chk("masterDivisor", {9'h000, masterDivisor}, (m <= 3'h4) ? m + 12'h001 : 12'h001);
    end
    for (int k = 0; k < 2; k++) begin
      wr(codec_cfg_pkg::ADDR_MODE, md[k]);
      wr(codec_cfg_pkg::ADDR_POWER, pw[k]);
      wr(codec_cfg_pkg::ADDR_GAIN, gn[k]);
      wr(codec_cfg_pkg::ADDR_DAC, dc[k]);
      chk("opModeData", {11'h000, cfg.opModeData}, {11'h000, md[k][0]});
      chk("mixedModeEnable", {11'h000, cfg.mixedModeEnable}, {11'h000, md[k][1]});
      chk("cascadeCount", {9'h000, cfg.cascadeCount}, {9'h000, md[k][6:4]});
      chk("analogTapPower", {11'h000, cfg.analogTapPower}, {11'h000, pw[k][1]});
      chk("inputAmpPower", {11'h000, cfg.inputAmpPower}, {11'h000, pw[k][2]});
      chk("adcPower", {11'h000, cfg.adcPower}, {11'h000, pw[k][3]});
      chk("inputGain", {9'h000, cfg.inputGain}, {9'h000, gn[k][2:0]});
      chk("modulatorReset", {11'h000, cfg.modulatorReset}, {11'h000, gn[k][3]});
      chk("outputGain", {9'h000, cfg.outputGain}, {9'h000, gn[k][6:4]});
      chk("dacAdvance", {7'h00, cfg.dacAdvance}, {7'h00, dc[k][4:0]});
    end
    // back to back, unmapped address among them
    u_dsp.send(3'h5, 8'hFF);
    u_dsp.send(codec_cfg_pkg::ADDR_DAC, 8'h13);
    u_dsp.send(codec_cfg_pkg::ADDR_GAIN, 8'h11);
    u_dsp.idle();
    rd(3'h5, v);
    chk("unmapped", {4'h0, v}, 12'h000);
    rd(codec_cfg_pkg::ADDR_DAC, v);
    chk("dacReg", {4'h0, v}, 12'h013);
    rd(codec_cfg_pkg::ADDR_GAIN, v);
    chk("gainReg", {4'h0, v}, 12'h011);
    // software reset; a write during the clear must be dropped
    u_dsp.send(codec_cfg_pkg::ADDR_MODE, 8'h80);
    u_dsp.send(codec_cfg_pkg::ADDR_POWER, 8'h0E);
    u_dsp.idle();
    chk("swResetBusy", {11'h000, swResetBusy}, 12'h001);
    for (int i = 0; i < 20 && swResetBusy !== 1'b0; i++) @(negedge mclk);
    chk("swResetBusy", {11'h000, swResetBusy}, 12'h000);
    chk("cfgCleared", {11'h000, cfg != '0}, 12'h000);
    for (int a = 0; a < 5; a++) begin
      rd(a[2:0], v);
      chk("afterSwReset", {4'h0, v}, 12'h000);
    end
    chk("sampleDivisor", sampleDivisor, 12'h0800);
    final_report();
  end
endmodule : tb
